// >>> sdp_defines.vh
// register map, field positions and reset values of the serial data/status/prescale block
`ifndef SDP_DEFINES_VH
`define SDP_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SDP_AW            12
`define SDP_OFF_CTRL0     12'h000
`define SDP_OFF_CTRL1     12'h004
`define SDP_OFF_DATA      12'h008
`define SDP_OFF_STAT      12'h00C
`define SDP_OFF_CPS       12'h010

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define SDP_DW            16
`define SDP_WLS_MSB       3
`define SDP_SCR_LSB       8
`define SDP_SCR_MSB       15
`define SDP_WLS_MIN       4'h3
`define SDP_C1_LBM        0
`define SDP_C1_SSE        1
`define SDP_C1_MS         2
`define SDP_C1_SOD        3
`define SDP_C1_W          4
`define SDP_ST_TFE        0
`define SDP_ST_TNF        1
`define SDP_ST_RNE        2
`define SDP_ST_RFF        3
`define SDP_ST_BSY        4
`define SDP_ST_W          5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SDP_CTRL0_RST     16'h0000
`define SDP_CTRL1_RST     4'h0
`define SDP_CPS_RST       7'h00
`define SDP_FIFO_DEPTH    16

`endif

// >>> sdp_fifo.v
// synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module sdp_fifo #(
   parameter W  = 16,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data,
   output wire         full
);

   reg  [W-1:0]  mem_q [0:D-1];
   reg  [AW:0]   wr_q;
   reg  [AW:0]   rd_q;
   wire          push;
   wire          pop;

   // ----------------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------------
   // pointers carry one extra wrap bit so full and empty are told apart
   assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem_q[rd_q[AW-1:0]];
   assign push      = in_valid && !full;
   assign pop       = out_valid && out_ready;

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   always @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> sdp_core.v
// serial port data port, status flags, prescaler and bit shifter behind an APB slave
// ----------------------------------------------------------------------
// Summary of operation
// - data port write pushes tx FIFO; read pops oldest rx FIFO entry
// - transmitter ignores upper unused bits, shifting only the low bits
// - received words are stored right-justified in the rx FIFO
// - status bit 4 busy while a frame runs or tx FIFO holds data
// - status bit 3 is one when rx FIFO is full, zero after reset
// - status bit 2 is one when rx FIFO holds data, zero after reset
// - status bit 1 is zero when tx FIFO full, one after reset
// - status bit 0 is one when tx FIFO empty, one after reset
// - prescale divisor reads back zero in its least significant bit
// - word length field codes 3 to 15 give 4 to 16 bits
// ----------------------------------------------------------------------
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defines.vh"

module sdp_core #(
   parameter DEPTH = `SDP_FIFO_DEPTH
) (
   input  wire                 clk,
   input  wire                 nrst,
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [`SDP_AW-1:0]   paddr,
   input  wire [31:0]          pwdata,
   output reg  [31:0]          prdata,
   output wire                 pready,
   output wire                 pslverr,
   input  wire                 sck_i,
   output wire                 sck_o,
   output wire                 sck_oe_n,
   input  wire                 cs_n_i,
   output wire                 cs_n_o,
   output wire                 cs_oe_n,
   input  wire                 sdi_i,
   output wire                 sdo_o,
   output wire                 sdo_oe_n
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // reserved codes below 3 fall back to the shortest word
   function [4:0] word_len;
      input [3:0] wls;
      begin
         if (wls < `SDP_WLS_MIN) begin
            word_len = 5'h04;
         end else begin
            word_len = {1'b0, wls} + 5'h01;
         end
      end
   endfunction

   function dec;
      input [`SDP_AW-1:0] a;
      input [`SDP_AW-1:0] off;
      begin
         dec = (a == off);
      end
   endfunction

   // ----------------------------------------------------------------------
   // registers and wires
   // ----------------------------------------------------------------------
   reg  [15:0]          ctrl0_q;
   reg  [`SDP_C1_W-1:0] ctrl1_q;
   reg  [7:1]           cps_q;
   reg                  state_q;
   reg  [15:0]          tx_sh_q;
   reg  [15:0]          rx_sh_q;
   reg  [4:0]           bit_q;
   reg                  sck_q;
   reg                  cs_n_q;
   reg  [14:0]          div_q;
   reg                  rx_wr_q;
   reg  [15:0]          rx_word_q;
   reg  [2:0]           sck_s_q;
   reg  [2:0]           cs_s_q;
   reg  [2:0]           sdi_s_q;
   reg                  sck_l_q;
   reg                  cs_l_q;
   reg                  sdi_l_q;
   wire [4:0]           wlen;
   wire [4:0]           shamt;
   wire                 sse;
   wire                 slave;
   wire [14:0]          half_per;
   wire                 tick;
   wire                 rise_ev;
   wire                 fall_ev;
   wire                 sdi_v;
   wire                 start;
   wire                 acc;
   wire                 setup;
   wire                 mapped;
   wire                 tx_in_ready;
   wire                 tx_valid;
   wire [15:0]          tx_data;
   wire                 tx_full;
   wire                 tx_pop;
   wire                 rx_valid;
   wire [15:0]          rx_data;
   wire                 rx_full;
   wire                 rx_pop;
   wire                 tx_push;
   wire                 busy;
   wire [`SDP_ST_W-1:0] status;

   assign wlen   = word_len(ctrl0_q[`SDP_WLS_MSB:0]);
   assign shamt  = 5'h10 - wlen;
   assign sse    = ctrl1_q[`SDP_C1_SSE];
   assign slave  = ctrl1_q[`SDP_C1_MS];

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   // zero-wait slave: read data is latched in the setup cycle
   assign setup   = psel && !penable;
   assign acc     = psel && penable;
   assign mapped  = dec(paddr, `SDP_OFF_CTRL0) || dec(paddr, `SDP_OFF_CTRL1) ||
                    dec(paddr, `SDP_OFF_DATA)  || dec(paddr, `SDP_OFF_STAT)  ||
                    dec(paddr, `SDP_OFF_CPS);
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign tx_push = acc && pwrite && dec(paddr, `SDP_OFF_DATA);
   assign rx_pop  = acc && !pwrite && dec(paddr, `SDP_OFF_DATA);

   // ----------------------------------------------------------------------
   // FIFOs
   // ----------------------------------------------------------------------
   sdp_fifo #(
      .W  (`SDP_DW),
      .D  (DEPTH),
      .AW ($clog2(DEPTH))
   ) u_tx_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (tx_push),
      .in_ready  (tx_in_ready),
      .in_data   (pwdata[15:0]),
      .out_valid (tx_valid),
      .out_ready (tx_pop),
      .out_data  (tx_data),
      .full      (tx_full)
   );

   sdp_fifo #(
      .W  (`SDP_DW),
      .D  (DEPTH),
      .AW ($clog2(DEPTH))
   ) u_rx_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (rx_wr_q),
      .in_ready  (),
      .in_data   (rx_word_q),
      .out_valid (rx_valid),
      .out_ready (rx_pop),
      .out_data  (rx_data),
      .full      (rx_full)
   );

   // ----------------------------------------------------------------------
   // status
   // ----------------------------------------------------------------------
   assign busy = (state_q == ST_RUN) || tx_valid;
   assign status[`SDP_ST_BSY] = busy;
   assign status[`SDP_ST_RFF] = rx_full;
   assign status[`SDP_ST_RNE] = rx_valid;
   assign status[`SDP_ST_TNF] = !tx_full;
   assign status[`SDP_ST_TFE] = !tx_valid;

   // ----------------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl0_q <= `SDP_CTRL0_RST;
         ctrl1_q <= `SDP_CTRL1_RST;
         cps_q   <= `SDP_CPS_RST;
         prdata  <= 32'h00000000;
      end else begin
         if (acc && pwrite) begin
            if (dec(paddr, `SDP_OFF_CTRL0)) begin
               ctrl0_q <= pwdata[15:0];
            end
            if (dec(paddr, `SDP_OFF_CTRL1)) begin
               ctrl1_q <= pwdata[`SDP_C1_W-1:0];
            end
            if (dec(paddr, `SDP_OFF_CPS)) begin
               cps_q <= pwdata[7:1];
            end
         end
         if (setup && !pwrite) begin
            // status is sampled one clock ahead of the access edge
            if (dec(paddr, `SDP_OFF_CTRL0)) begin
               prdata <= {16'h0000, ctrl0_q};
            end else if (dec(paddr, `SDP_OFF_CTRL1)) begin
               prdata <= {28'h0000000, ctrl1_q};
            end else if (dec(paddr, `SDP_OFF_DATA)) begin
               prdata <= rx_valid ? {16'h0000, rx_data} : 32'h00000000;
            end else if (dec(paddr, `SDP_OFF_STAT)) begin
               prdata <= {27'h0000000, status};
            end else if (dec(paddr, `SDP_OFF_CPS)) begin
               prdata <= {24'h000000, cps_q, 1'b0};
            end else begin
               prdata <= 32'h00000000;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   // a level is accepted only once the second and third stages agree
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sck_s_q <= 3'h0;
         cs_s_q  <= 3'h7;
         sdi_s_q <= 3'h0;
         sck_l_q <= 1'b0;
         cs_l_q  <= 1'b1;
         sdi_l_q <= 1'b0;
      end else begin
         sck_s_q <= {sck_s_q[1:0], sck_i};
         cs_s_q  <= {cs_s_q[1:0], cs_n_i};
         sdi_s_q <= {sdi_s_q[1:0], sdi_i};
         if (sck_s_q[1] == sck_s_q[2]) begin
            sck_l_q <= sck_s_q[2];
         end
         if (cs_s_q[1] == cs_s_q[2]) begin
            cs_l_q <= cs_s_q[2];
         end
         if (sdi_s_q[1] == sdi_s_q[2]) begin
            sdi_l_q <= sdi_s_q[2];
         end
      end
   end

   // ----------------------------------------------------------------------
   // bit clock prescaler
   // ----------------------------------------------------------------------
   // half a bit lasts (divisor/2)*(1+rate); divisor below 2 acts as 2
   assign half_per = ((cps_q == 7'h00) ? 15'h0001 : {8'h00, cps_q}) *
                     ({7'h00, ctrl0_q[`SDP_SCR_MSB:`SDP_SCR_LSB]} + 15'h0001);
   assign tick     = (div_q == half_per - 15'h0001);

   assign rise_ev = slave ? (sck_s_q[2] && sck_s_q[1] && !sck_l_q && !cs_l_q)
                          : (tick && !sck_q);
   assign fall_ev = slave ? (!sck_s_q[2] && !sck_s_q[1] && sck_l_q && !cs_l_q)
                          : (tick && sck_q);
   assign sdi_v   = ctrl1_q[`SDP_C1_LBM] ? tx_sh_q[15] : sdi_l_q;

   // ----------------------------------------------------------------------
   // shifter
   // ----------------------------------------------------------------------
   // a slave with nothing queued still answers a frame, sending zeros
   // a master waits for select to be high for one clock, so the peer sees each word apart
   assign start  = (state_q == ST_IDLE) && sse &&
                   (slave ? !cs_l_q : (tx_valid && cs_n_q));
   assign tx_pop = start && tx_valid;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q   <= ST_IDLE;
         tx_sh_q   <= 16'h0000;
         rx_sh_q   <= 16'h0000;
         bit_q     <= 5'h00;
         sck_q     <= 1'b0;
         cs_n_q    <= 1'b1;
         div_q     <= 15'h0000;
         rx_wr_q   <= 1'b0;
         rx_word_q <= 16'h0000;
      end else begin
         rx_wr_q <= 1'b0;
         div_q   <= (tick || state_q == ST_IDLE) ? 15'h0000 : div_q + 15'h0001;
         case (state_q)
            ST_IDLE: begin
               sck_q  <= 1'b0;
               cs_n_q <= 1'b1;
               if (start) begin
                  state_q <= ST_RUN;
                  cs_n_q  <= slave;
                  bit_q   <= 5'h00;
                  rx_sh_q <= 16'h0000;
                  // upper unused bits fall off the top of the shifter
                  tx_sh_q <= tx_valid ? (tx_data << shamt) : 16'h0000;
               end
            end
            ST_RUN: begin
               if (!sse || (slave && cs_l_q)) begin
                  state_q <= ST_IDLE;
               end else begin
                  if (!slave && tick) begin
                     sck_q <= !sck_q;
                  end
                  if (rise_ev) begin
                     rx_sh_q <= {rx_sh_q[14:0], sdi_v};
                  end
                  if (fall_ev) begin
                     tx_sh_q <= {tx_sh_q[14:0], 1'b0};
                     bit_q   <= bit_q + 5'h01;
                     if (bit_q == wlen - 5'h01) begin
                        state_q   <= ST_IDLE;
                        rx_wr_q   <= 1'b1;
                        rx_word_q <= rx_sh_q;
                     end
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------------
   assign sck_o    = sck_q;
   assign sck_oe_n = !sse || slave;
   assign cs_n_o   = cs_n_q;
   assign cs_oe_n  = !sse || slave;
   assign sdo_o    = tx_sh_q[15];
   assign sdo_oe_n = !sse || (slave && (cs_l_q || ctrl1_q[`SDP_C1_SOD]));

endmodule

`default_nettype wire

// >>> sdp_core_checker.sv
// protocol and status checks for the serial data, status and prescale block
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defines.vh"

module sdp_core_checker (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        sck_o,
   input  wire logic        sck_oe_n,
   input  wire logic        cs_n_o,
   input  wire logic        cs_oe_n,
   input  wire logic        sdo_o,
   input  wire logic        sdo_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   wire mapped  = paddr == `SDP_OFF_CTRL0 || paddr == `SDP_OFF_CTRL1 || paddr == `SDP_OFF_DATA
                  || paddr == `SDP_OFF_STAT || paddr == `SDP_OFF_CPS;
   wire access  = psel && penable;
   wire rd_set  = psel && !penable && !pwrite;
   wire st_rd   = rd_set && paddr == `SDP_OFF_STAT;

   a_ready_always: assert property (pready)
      else $error("pready low");
   a_err_phase: assert property (pslverr |-> access)
      else $error("pslverr outside access phase");
   a_err_unmapped: assert property (access && !mapped |-> pslverr)
      else $error("no error on unmapped access");
   a_err_mapped: assert property (access && mapped |-> !pslverr)
      else $error("error on mapped access");
   a_unmapped_zero: assert property (rd_set && !mapped |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_cps_lsb: assert property (rd_set && paddr == `SDP_OFF_CPS |=> !prdata[0])
      else $error("prescale lsb reads one");
   a_tx_empty_room: assert property (st_rd |=> !prdata[0] || prdata[1])
      else $error("tx empty yet full");
   a_rx_full_data: assert property (st_rd |=> !prdata[3] || prdata[2])
      else $error("rx full yet empty");
   a_tx_data_busy: assert property (st_rd |=> prdata[0] || prdata[4])
      else $error("tx holds data but not busy");
   a_oe_pair: assert property (sck_oe_n == cs_oe_n)
      else $error("clock and select drive differ");
   a_sck_idle: assert property (cs_n_o |-> !sck_o)
      else $error("clock high outside frame");
   a_sdo_hold: assert property (!cs_n_o && !$past(cs_n_o) && !$fell(sck_o) |-> $stable(sdo_o))
      else $error("data out moved away from clock fall");
   a_master_sdo_drive: assert property (!sck_oe_n |-> !sdo_oe_n)
      else $error("enabled master leaves data out undriven");
endmodule

bind sdp_core sdp_core_checker u_sdp_core_checker (
   .clk, .nrst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .sck_o, .sck_oe_n, .cs_n_o, .cs_oe_n, .sdo_o, .sdo_oe_n
);
`default_nettype wire

// >>> sdp_slave_model.sv
// serial peer model: a slave that answers each frame and records what it heard
`timescale 1ns/10ps
`default_nettype none

module sdp_slave_model (
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       mosi,
   input  wire logic [4:0] wlen,
   output var  logic       miso
);
   int          idx;
   int          cnt;
   logic        act;
   logic [15:0] sh;
   logic [15:0] rep;
   logic [15:0] got [0:31];

   initial begin
      cnt  = 0;
      act  = 1'b0;
      miso = 1'b0;
   end
   // the answer changes per frame so a stale or repeated word shows up
   always @(negedge cs_n) begin
      rep  = 16'hA5C3 ^ {4{cnt[3:0]}};
      idx  = int'(wlen) - 1;
      sh   = 16'h0;
      act  = 1'b1;
      miso = rep[idx];
   end
   always @(posedge sck) begin
      if (act) begin
         sh = {sh[14:0], mosi};
      end
   end
   // past the last bit the line shows the inverse, never a believable hold
   always @(negedge sck) begin
      if (act) begin
         idx  = idx - 1;
         miso = (idx >= 0) ? rep[idx] : ~miso;
      end
   end
   always @(posedge cs_n) begin
      if (act) begin
         got[cnt] = sh;
         cnt      = cnt + 1;
      end
      act  = 1'b0;
      miso = ~miso;
   end
endmodule
`default_nettype wire

// >>> test_sdp_core.sv
// self-checking bench for the serial data, status and prescale block
`timescale 1ns/10ps
`default_nettype none
`include "sdp_defines.vh"

module test_sdp_core;
   logic        clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [4:0]  wl;
   logic [31:0] r;
   logic        e;
   logic        sck_i;
   logic        cs_n_i;
   int          mismatches;
   int          n_checks;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         sck_o;
   wire         cs_n_o;
   wire         sdo_o;
   wire         sdi_i;

   sdp_core u_sdp_core (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck_i(sck_i), .sck_o(sck_o), .sck_oe_n(), .cs_n_i(cs_n_i), .cs_n_o(cs_n_o), .cs_oe_n(),
      .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_n()
   );
   sdp_slave_model u_sdp_slave_model (
      .sck(sck_o), .cs_n(cs_n_o), .mosi(sdo_o), .wlen(wl), .miso(sdi_i)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // one transfer; read data and error are taken at the edge that sees pready
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         end_sim();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(`SDP_OFF_STAT, 1'b0, 32'h0);
         n++;
      end while (r[`SDP_ST_BSY] !== 1'b0 && n < 2000);
      if (n >= 2000) begin
         mismatches++;
         end_sim();
      end
   endtask

   // first two words span the full value range, the rest vary per slot
   function automatic logic [15:0] wv(input int k);
      logic [15:0] kk;
      kk = k[15:0];
      wv = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'h5A3C ^ (kk * 16'h0101);
   endfunction

   task automatic run(input logic [3:0] code, input int n);
      logic [15:0] m;
      logic [15:0] rp;
      int          c0;
      m  = 16'((17'h1 << (code + 1)) - 1);
      wl = 5'(code) + 5'd1;
      c0 = u_sdp_slave_model.cnt;
      apb(`SDP_OFF_CTRL1, 1'b1, 32'h0);
      apb(`SDP_OFF_CTRL0, 1'b1, {28'h0, code});
      // junk in the upper half must never reach the wire; a full fifo drops the extra word
      for (int k = 0; k < n + (n == 16); k++) begin
         apb(`SDP_OFF_DATA, 1'b1, {16'hDEAD, wv(k)});
      end
      apb(`SDP_OFF_STAT, 1'b0, 32'h0);
      chk("status loaded", {27'h0, 1'b1, 2'b00, n < 16, 1'b0}, r);
      apb(`SDP_OFF_CTRL1, 1'b1, 32'h2);
      wait_idle();
      repeat (8) @(posedge clk);
      apb(`SDP_OFF_STAT, 1'b0, 32'h0);
      chk("status sent", {27'h0, 1'b0, n == 16, 3'b111}, r);
      chk("frames", 32'(n), 32'(u_sdp_slave_model.cnt - c0));
      for (int k = 0; k < n; k++) begin
         chk("wire word", {16'h0, m & wv(k)}, {16'h0, u_sdp_slave_model.got[c0 + k]});
         rp = 16'hA5C3 ^ {4{4'(c0 + k)}};
         apb(`SDP_OFF_DATA, 1'b0, 32'h0);
         chk("rx word", {16'h0, m & rp}, r);
      end
      apb(`SDP_OFF_STAT, 1'b0, 32'h0);
      chk("status drained", 32'h3, r);
      $display("test frames code %0d words %0d done", code, n);
   endtask

   initial begin
      nrst       = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 12'h000;
      pwdata     = 32'h0;
      wl         = 5'd8;
      sck_i      = 1'b0;
      cs_n_i     = 1'b1;
      mismatches = 0;
      n_checks   = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      apb(`SDP_OFF_STAT, 1'b0, 32'h0);
      chk("status reset", 32'h3, r);
      apb(`SDP_OFF_DATA, 1'b0, 32'h0);
      chk("empty rx read", 32'h0, r);
      apb(`SDP_OFF_CPS, 1'b0, 32'h0);
      chk("prescale reset", 32'h0, r);
      $display("test reset values done");
      apb(`SDP_OFF_CPS, 1'b1, 32'hFF);
      apb(`SDP_OFF_CPS, 1'b0, 32'h0);
      chk("prescale odd", 32'hFE, r);
      apb(`SDP_OFF_CPS, 1'b1, 32'h10);
      apb(`SDP_OFF_CPS, 1'b0, 32'h0);
      chk("prescale even", 32'h10, r);
      apb(12'h014, 1'b0, 32'h0);
      chk("unmapped read", 32'h0, r);
      chk("unmapped read error", 32'h1, {31'h0, e});
      apb(12'h018, 1'b1, 32'h5);
      chk("unmapped write error", 32'h1, {31'h0, e});
      $display("test registers done");
      run(4'h3, 2);
      run(4'hF, 2);
      run(4'h7, 16);
      // slave with loopback: the bench is the far master, the word comes back on the rx side
      apb(`SDP_OFF_CTRL1, 1'b1, 32'h0);
      apb(`SDP_OFF_CTRL0, 1'b1, 32'h7);
      apb(`SDP_OFF_CPS, 1'b1, 32'h2);
      apb(`SDP_OFF_DATA, 1'b1, 32'h0000C35A);
      apb(`SDP_OFF_CTRL1, 1'b1, 32'h7);
      cs_n_i <= 1'b0;
      repeat (8) @(posedge clk);
      for (int b = 0; b < 8; b++) begin
         sck_i <= 1'b1;
         repeat (8) @(posedge clk);
         sck_i <= 1'b0;
         repeat (8) @(posedge clk);
      end
      cs_n_i <= 1'b1;
      repeat (8) @(posedge clk);
      apb(`SDP_OFF_DATA, 1'b0, 32'h0);
      chk("slave loop word", 32'h5A, r);
      $display("test slave loopback done");
      end_sim();
   end
endmodule
`default_nettype wire
